// File: common/smbus_slave_defs.svh
`ifndef SMBUS_SLAVE_DEFS_SVH
`define SMBUS_SLAVE_DEFS_SVH

`define ADDR_DEFAULT    7'h2e
`define ADDR_SEL_BASE   6'h16
`define ARA_ADDR        7'h0c
`define BYTE_BITS       4'h8
`define ACK_CLOCK       4'h9
`define ADDR_LATCH_BIT  4'h7
`define STRAP_SETTLE    3'h7
`define TIMEOUT_MS      35
`define CLK_KHZ         200000
`define TIMEOUT_CYCLES  (`TIMEOUT_MS * `CLK_KHZ)
`define FIFO_WIDTH      16
`define FIFO_DEPTH      8

`endif

// File: common/smbus_slave_pkg.sv
package smbus_slave_pkg;

    typedef enum logic [2:0]
    {
        st_idle,
        st_addr,
        st_rd_ack,
        st_wr,
        st_rd,
        st_ignore
    } state_t;

endpackage : smbus_slave_pkg

// File: hdl/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
    parameter int W = 1
) (
    input  wire logic         clock,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);

    logic [W-1:0] s1_ff;
    logic [W-1:0] s2_ff;
    logic [W-1:0] s3_ff;
    logic [W-1:0] out_ff;

    // Idle bus and straps read high until the pins settle
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_ff  <= '1;
            s2_ff  <= '1;
            s3_ff  <= '1;
            out_ff <= '1;
        end
        else
        begin
            s1_ff  <= din;
            s2_ff  <= s1_ff;
            s3_ff  <= s2_ff;
            out_ff <= (s2_ff & s3_ff) | (out_ff & (s2_ff ^ s3_ff));
        end
    end

    assign dout = out_ff;

endmodule : pin_sync

`default_nettype wire

// File: hdl/byte_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module byte_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0]    wr_ff;
    logic [AW-1:0]    rd_ff;
    logic [AW:0]      cnt_ff;

    wire do_push = in_valid & in_ready;
    wire do_pop  = out_valid & out_ready;

    assign in_ready  = (cnt_ff != (AW+1)'(DEPTH));
    assign out_valid = (cnt_ff != '0);
    assign out_data  = mem_ff[rd_ff];

    always_ff @(posedge clock)
    begin
        if (do_push)
            mem_ff[wr_ff] <= in_data;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_ff  <= '0;
            rd_ff  <= '0;
            cnt_ff <= '0;
        end
        else
        begin
            if (do_push)
                wr_ff <= (wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + 1'b1;
            if (do_pop)
                rd_ff <= (rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + 1'b1;
            cnt_ff <= cnt_ff + (AW+1)'(do_push) - (AW+1)'(do_pop);
        end
    end

endmodule : byte_fifo

`default_nettype wire

// File: hdl/smbus_slave.sv
`timescale 1ns/1ps
`default_nettype none
`include "smbus_slave_defs.svh"

module smbus_slave #(
    parameter int unsigned TIMEOUT_CYCLES = `TIMEOUT_CYCLES
) (
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    output logic            alert_out,
    output logic            alert_oe,
    input  wire logic       address_strap_select_pin,
    input  wire logic       addr_select_pin,
    input  wire logic       timeout_disable,
    input  wire logic       alert_cond,
    input  wire logic       status_read,
    output logic      [7:0] rd_ptr,
    input  wire logic [7:0] rd_data,
    output logic            wr_valid,
    input  wire logic       wr_ready,
    output logic      [7:0] wr_addr,
    output logic      [7:0] wr_data
);

    smbus_slave_pkg::state_t state_ff;

    logic [3:0]  sync_q;
    logic        scl_d_ff;
    logic        sda_d_ff;
    logic [3:0]  cnt_ff;
    logic [7:0]  rx_ff;
    logic [7:0]  tx_ff;
    logic        sda_oe_ff;
    logic [1:0]  byte_idx_ff;
    logic [7:0]  ptr_ff;
    logic [6:0]  own_ff;
    logic        frozen_ff;
    logic [6:0]  sel_addr_ff;
    logic [2:0]  init_cnt_ff;
    logic        strap_ok_ff;
    logic        ara_ff;
    logic        ara_done_ff;
    logic        status_seen_ff;
    logic        alert_ff;
    logic [22:0] idle_cnt_ff;
    logic        fifo_in_ready;
    logic [15:0] fifo_out;

    // Pins come from another domain, so all pass the three-stage filter
    pin_sync #(
        .W (4)
    ) u_sync (
        .clock (clock),
        .rst_n (rst_n),
        .din   ({scl_in, sda_in, address_strap_select_pin, addr_select_pin}),
        .dout  (sync_q)
    );

    wire scl_s     = sync_q[3];
    wire sda_s     = sync_q[2];
    wire strap_sel = sync_q[1];
    wire strap_bit = sync_q[0];

    wire scl_rise  = scl_s & ~scl_d_ff;
    wire scl_fall  = ~scl_s & scl_d_ff;
    wire start_det = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
    wire stop_det  = scl_s & scl_d_ff & ~sda_d_ff & sda_s;
    wire bus_moved = (scl_s ^ scl_d_ff) | (sda_s ^ sda_d_ff);

    wire       in_frame  = (state_ff != smbus_slave_pkg::st_idle);
    wire       timed_out = in_frame & ~timeout_disable &
                           (idle_cnt_ff == 23'(TIMEOUT_CYCLES - 1));
    wire       abort     = start_det | stop_det | timed_out;

    wire [6:0] cur_addr  = frozen_ff ? own_ff : sel_addr_ff;
    wire       own_hit   = (rx_ff[7:1] == cur_addr);
    wire       ara_hit   = (rx_ff[7:1] == `ARA_ADDR) & rx_ff[0] & alert_ff;
    wire       addr_ack  = own_hit | ara_hit;
    wire       byte_end  = scl_fall & (cnt_ff == `BYTE_BITS) & ~abort;
    wire       ack_end   = scl_fall & (cnt_ff == `ACK_CLOCK) & ~abort;
    wire       bit_fall  = scl_fall & (cnt_ff != '0) & (cnt_ff < `BYTE_BITS) & ~abort;
    wire       in_wr     = (state_ff == smbus_slave_pkg::st_wr);
    wire       in_rd     = (state_ff == smbus_slave_pkg::st_rd);
    // Byte index counts the address byte as zero
    wire       push_now  = byte_end & in_wr & (byte_idx_ff == 2'h2);
    wire       ara_sent  = byte_end & in_rd & ara_ff;
    wire       lost_arb  = scl_rise & in_rd & (cnt_ff < `BYTE_BITS) &
                           ~sda_oe_ff & ~sda_s;
    wire       alert_rel = ara_done_ff & status_seen_ff & ~alert_cond;
    wire       latch_own = scl_rise & ~abort & ~frozen_ff & (cnt_ff == `ADDR_LATCH_BIT) &
                           (state_ff == smbus_slave_pkg::st_addr) &
                           (rx_ff[6:0] == sel_addr_ff);

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            scl_d_ff <= 1'b1;
            sda_d_ff <= 1'b1;
        end
        else
        begin
            scl_d_ff <= scl_s;
            sda_d_ff <= sda_s;
        end
    end

    // Straps are caught once the filter has settled after reset
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            init_cnt_ff <= '0;
            strap_ok_ff <= 1'b0;
            sel_addr_ff <= `ADDR_DEFAULT;
        end
        else if (!strap_ok_ff)
        begin
            init_cnt_ff <= init_cnt_ff + 3'h1;
            if (init_cnt_ff == `STRAP_SETTLE)
            begin
                strap_ok_ff <= 1'b1;
                sel_addr_ff <= strap_sel ? `ADDR_DEFAULT : {`ADDR_SEL_BASE, strap_bit};
            end
        end
    end

    // Later strap changes have no effect once frozen
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            frozen_ff <= 1'b0;
            own_ff    <= '0;
        end
        else if (latch_own)
        begin
            frozen_ff <= 1'b1;
            own_ff    <= sel_addr_ff;
        end
    end

    // Any edge on either line counts as activity
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            idle_cnt_ff <= '0;
        else if (bus_moved || !in_frame || timed_out)
            idle_cnt_ff <= '0;
        else
            idle_cnt_ff <= idle_cnt_ff + 23'h1;
    end

    // Bit sampling on rising clock
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            rx_ff <= '0;
        else if (scl_rise && cnt_ff < `BYTE_BITS)
            rx_ff <= {rx_ff[6:0], sda_s};
    end

    // Pointer changes only on the first byte of a write
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            ptr_ff <= '0;
        else if (byte_end && in_wr && byte_idx_ff == 2'h1)
            ptr_ff <= rx_ff;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_ff    <= smbus_slave_pkg::st_idle;
            cnt_ff      <= '0;
            tx_ff       <= '0;
            sda_oe_ff   <= 1'b0;
            byte_idx_ff <= '0;
            ara_ff      <= 1'b0;
        end
        else if (start_det)
        begin
            state_ff    <= smbus_slave_pkg::st_addr;
            cnt_ff      <= '0;
            byte_idx_ff <= '0;
            sda_oe_ff   <= 1'b0;
            ara_ff      <= 1'b0;
        end
        else if (stop_det || timed_out)
        begin
            state_ff  <= smbus_slave_pkg::st_idle;
            sda_oe_ff <= 1'b0;
        end
        else if (lost_arb)
        begin
            state_ff  <= smbus_slave_pkg::st_ignore;
            sda_oe_ff <= 1'b0;
        end
        else if (scl_rise && in_frame)
        begin
            cnt_ff <= (cnt_ff < `BYTE_BITS) ? cnt_ff + 4'h1 : `ACK_CLOCK;
        end
        else if (byte_end)
        begin
            // Eighth clock fall: acknowledge decided here, driven while clock low
            case (state_ff)
                smbus_slave_pkg::st_addr:
                begin
                    if (addr_ack)
                    begin
                        sda_oe_ff <= 1'b1;
                        ara_ff    <= ara_hit;
                        tx_ff     <= ara_hit ? {cur_addr, 1'b0} : rd_data;
                        state_ff  <= rx_ff[0] ? smbus_slave_pkg::st_rd_ack
                                              : smbus_slave_pkg::st_wr;
                    end
                    else
                        state_ff <= smbus_slave_pkg::st_ignore;
                end
                smbus_slave_pkg::st_wr:
                begin
                    if (byte_idx_ff == 2'h1 || (byte_idx_ff == 2'h2 && fifo_in_ready))
                        sda_oe_ff <= 1'b1;
                    else
                        state_ff <= smbus_slave_pkg::st_ignore;
                end
                smbus_slave_pkg::st_rd:
                    sda_oe_ff <= 1'b0;
                default:
                    sda_oe_ff <= 1'b0;
            endcase
        end
        else if (ack_end)
        begin
            cnt_ff      <= '0;
            byte_idx_ff <= byte_idx_ff + 2'h1;
            case (state_ff)
                smbus_slave_pkg::st_rd_ack:
                begin
                    state_ff  <= smbus_slave_pkg::st_rd;
                    sda_oe_ff <= ~tx_ff[7];
                    tx_ff     <= {tx_ff[6:0], 1'b1};
                end
                smbus_slave_pkg::st_rd:
                begin
                    state_ff  <= smbus_slave_pkg::st_ignore;
                    sda_oe_ff <= 1'b0;
                end
                default:
                    sda_oe_ff <= 1'b0;
            endcase
        end
        else if (bit_fall && in_rd)
        begin
            sda_oe_ff <= ~tx_ff[7];
            tx_ff     <= {tx_ff[6:0], 1'b1};
        end
    end

    // Alert holds until answered, status seen and the cause is gone
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            alert_ff       <= 1'b0;
            ara_done_ff    <= 1'b0;
            status_seen_ff <= 1'b0;
        end
        else
        begin
            alert_ff <= alert_cond | (alert_ff & ~alert_rel);
            // A fresh answer outranks the release of the old one
            if (ara_sent)
                ara_done_ff <= 1'b1;
            else if (alert_rel)
                ara_done_ff <= 1'b0;
            if (alert_rel)
                status_seen_ff <= 1'b0;
            else if (status_read && ara_done_ff)
                status_seen_ff <= 1'b1;
        end
    end

    // Full buffer refuses the data byte rather than dropping it
    byte_fifo #(
        .WIDTH (`FIFO_WIDTH),
        .DEPTH (`FIFO_DEPTH)
    ) u_fifo (
        .clock     (clock),
        .rst_n     (rst_n),
        .in_valid  (push_now),
        .in_ready  (fifo_in_ready),
        .in_data   ({ptr_ff, rx_ff}),
        .out_valid (wr_valid),
        .out_ready (wr_ready),
        .out_data  (fifo_out)
    );

    assign wr_addr   = fifo_out[15:8];
    assign wr_data   = fifo_out[7:0];
    assign rd_ptr    = ptr_ff;
    assign sda_out   = 1'b0;
    assign sda_oe    = sda_oe_ff;
    assign alert_out = 1'b0;
    assign alert_oe  = alert_ff;

endmodule : smbus_slave

`default_nettype wire

// File: tb/smbus_slave_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module smbus_slave_monitor #(
    parameter int unsigned TIMEOUT_CYCLES = 200
) (
    input wire logic       clock,
    input wire logic       rst_n,
    input wire logic       scl_in,
    input wire logic       sda_in,
    input wire logic       sda_out,
    input wire logic       sda_oe,
    input wire logic       alert_out,
    input wire logic       alert_oe,
    input wire logic       timeout_disable,
    input wire logic       alert_cond,
    input wire logic [7:0] rd_ptr,
    input wire logic       wr_valid,
    input wire logic       wr_ready,
    input wire logic [7:0] wr_addr,
    input wire logic [7:0] wr_data
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    logic [1:0]  pins_ff;
    logic [31:0] quiet_ff;
    logic [31:0] nxt_quiet;
    logic        bus_still;

    assign bus_still = {scl_in, sda_in} == pins_ff;
    assign nxt_quiet = bus_still ? quiet_ff + 32'h1 : 32'h0;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pins_ff  <= 2'h3;
            quiet_ff <= 32'h0;
        end
        else
        begin
            pins_ff  <= {scl_in, sda_in};
            quiet_ff <= nxt_quiet;
        end
    end

    sequence alert_raise;
        $rose(alert_cond) ##1 alert_cond;
    endsequence
    sequence word_held;
        wr_valid && $stable(wr_addr) && $stable(wr_data);
    endsequence

    AST_SDA_LOW_ONLY: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("data drive changed while clock high");
    AST_OD_VALUES: assert property (sda_out == 1'b0 && alert_out == 1'b0)
        else $error("open drain value not low");
    AST_ALERT_SET: assert property (alert_raise |-> ##[0:2] alert_oe)
        else $error("alert not asserted");
    AST_ALERT_HOLD: assert property (alert_oe && alert_cond |=> alert_oe)
        else $error("alert released while cause present");
    AST_ALERT_CLEAR: assert property ($fell(alert_oe) |-> !alert_cond && !$past(alert_cond))
        else $error("alert released too early");
    AST_WORD_HOLD: assert property (wr_valid && !wr_ready |=> word_held)
        else $error("queued write changed before taken");
    AST_PUSH_LOW: assert property ($rose(wr_valid) |-> !scl_in)
        else $error("write queued outside clock low");
    AST_PTR_LOW: assert property ($changed(rd_ptr) |-> !scl_in)
        else $error("pointer changed outside clock low");
    // Filter lag and edge detect need a small margin
    AST_TIMEOUT: assert property (quiet_ff > TIMEOUT_CYCLES + 16 && !timeout_disable |-> !sda_oe)
        else $error("data held past bus timeout");
endmodule : smbus_slave_monitor

bind smbus_slave smbus_slave_monitor #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) mon_u (
    .clock(clock), .rst_n(rst_n), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .alert_out(alert_out), .alert_oe(alert_oe), .timeout_disable(timeout_disable),
    .alert_cond(alert_cond), .rd_ptr(rd_ptr), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_addr(wr_addr), .wr_data(wr_data)
);

`default_nettype wire

// File: tb/smbus_host.sv
`timescale 1ns/1ps
`default_nettype none

module smbus_host #(
    parameter int HALF = 8
) (
    input  wire logic clock,
    input  wire logic sda_line,
    output var logic  scl,
    output var logic  sda_drv
);
    // Released lines read high through the pull-up
    initial
    begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask : tick

    // Works as repeated start too: data rises while clock low
    task automatic start();
        tick(1);
        sda_drv <= 1'b1;
        tick(HALF);
        scl <= 1'b1;
        tick(HALF);
        sda_drv <= 1'b0;
        tick(HALF);
        scl <= 1'b0;
    endtask : start

    task automatic stop();
        tick(1);
        sda_drv <= 1'b0;
        tick(HALF);
        scl <= 1'b1;
        tick(HALF);
        sda_drv <= 1'b1;
        tick(HALF);
    endtask : stop

    // Data moves one cycle after the clock fall; low half stays HALF cycles
    task automatic bit_xfer(input logic b, output logic r);
        tick(1);
        sda_drv <= b;
        tick(HALF - 1);
        scl <= 1'b1;
        tick(HALF);
        r = sda_line;
        scl <= 1'b0;
    endtask : bit_xfer

    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bit_xfer(b[i], r);
        end
        bit_xfer(1'b1, r);
        ack = ~r;
    endtask : send_byte

    task automatic recv_byte(output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bit_xfer(1'b1, r);
            b[i] = r;
        end
        bit_xfer(1'b1, r);
    endtask : recv_byte
endmodule : smbus_host

`default_nettype wire

// File: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic        alert_cond = 1'b0;
    logic        status_read = 1'b0;
    logic        wr_ready = 1'b0;
    logic        hold = 1'b0;
    logic        timeout_disable = 1'b0;
    logic        strap_mode = 1'b1;
    logic        strap_pin = 1'b0;
    logic [7:0]  rd_data = 8'h00;
    logic [31:0] rnd = 32'h831b;
    logic [7:0]  regs [256];
    logic [7:0]  exp_regs [256];
    logic [15:0] exp_q [$];
    int          fail_count = 0;
    int          checks = 0;
    logic        scl, host_sda, sda_out, sda_oe, alert_out, alert_oe, wr_valid;
    logic [7:0]  rd_ptr, wr_addr, wr_data;
    wire         sda_line = host_sda & (sda_oe ? sda_out : 1'b1);

    always #2.5 clock = ~clock;

    smbus_host host_u (.clock(clock), .sda_line(sda_line), .scl(scl), .sda_drv(host_sda));

    smbus_slave #(.TIMEOUT_CYCLES(200)) dut_u (
        .clock(clock), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
        .sda_oe(sda_oe), .alert_out(alert_out), .alert_oe(alert_oe),
        .address_strap_select_pin(strap_mode), .addr_select_pin(strap_pin), .timeout_disable(timeout_disable),
        .alert_cond(alert_cond), .status_read(status_read), .rd_ptr(rd_ptr), .rd_data(rd_data),
        .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data)
    );

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp)
        begin
            $display("[ERR] %s expected %h seen %h", what, exp, got);
            fail_count++;
        end
    endtask : check

    task automatic end_sim();
        if (fail_count == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_sim

    // Register file behind the pointer, plus the write scoreboard
    always @(posedge clock)
    begin
        rnd <= lfsr(rnd);
        wr_ready <= ~hold & rnd[3];
        rd_data <= regs[rd_ptr];
        if (wr_valid === 1'b1 && wr_ready === 1'b1)
        begin
            regs[wr_addr] <= wr_data;
            if (exp_q.size() == 0)
                check("fifo_extra", 16'h0, 16'hffff);
            else
                check("fifo_word", exp_q.pop_front(), {wr_addr, wr_data});
        end
    end

    task automatic wr_op(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d, input int n,
                         input bit stp, output logic [3:0] ak);
        ak = 4'h0;
        host_u.start();
        host_u.send_byte({a, 1'b0}, ak[0]);
        if (n > 0) host_u.send_byte(c, ak[1]);
        if (n > 1) host_u.send_byte(d, ak[2]);
        if (n > 2) host_u.send_byte(~d, ak[3]);
        if (stp) host_u.stop();
    endtask : wr_op

    task automatic rd_op(input logic [6:0] a, output logic ack, output logic [7:0] d);
        host_u.start();
        host_u.send_byte({a, 1'b1}, ack);
        host_u.recv_byte(d);
        host_u.stop();
    endtask : rd_op

    task automatic drain();
        int i;
        i = 0;
        while (wr_valid !== 1'b0 && i < 400)
        begin
            @(posedge clock);
            i++;
        end
        if (i == 400)
        begin
            fail_count++;
            end_sim();
        end
    endtask : drain

    initial
    begin
        logic [3:0] ak;
        logic [7:0] c, d, got;
        logic       ack;
        for (int i = 0; i < 256; i++)
        begin
            regs[i] = 8'(i) ^ 8'h5a;
            exp_regs[i] = 8'(i) ^ 8'h5a;
        end
        repeat (20) @(posedge clock);
        check("reset", 16'h0, {5'h0, sda_oe, alert_oe, wr_valid, rd_ptr});
        rst_n <= 1'b1;
        repeat (20) @(posedge clock);
        for (int i = 0; i < 3; i++)
        begin
            c = rnd[7:0];
            d = rnd[15:8];
            exp_q.push_back({c, d});
            exp_regs[c] = d;
            wr_op(7'h2e, c, d, 2, 1'b1, ak);
            check("wr_ack", 16'h7, {12'h0, ak});
        end
        // No stop between pointer set and read
        wr_op(7'h2e, c, 8'h00, 1, 1'b0, ak);
        check("send_ack", 16'h3, {12'h0, ak});
        check("ptr", {8'h0, c}, {8'h0, rd_ptr});
        rd_op(7'h2e, ack, got);
        check("rs_read", {7'h0, 1'b1, exp_regs[c]}, {7'h0, ack, got});
        rd_op(7'h2e, ack, got);
        check("rx_read", {7'h0, 1'b1, exp_regs[c]}, {7'h0, ack, got});
        wr_op(7'h2f, ~c, 8'h11, 2, 1'b1, ak);
        check("foreign", {8'h0, c}, {4'h0, ak, rd_ptr});
        rd_op(7'h0c, ack, got);
        check("ara_idle", 16'h0, {15'h0, ack});
        c = rnd[7:0];
        d = rnd[15:8];
        exp_q.push_back({c, d});
        exp_regs[c] = d;
        wr_op(7'h2e, c, d, 3, 1'b1, ak);
        check("wr3_ack", 16'h7, {12'h0, ak});
        // User side stalls: eight words fit, the ninth is refused
        drain();
        hold <= 1'b1;
        for (int i = 0; i < 9; i++)
        begin
            d = rnd[7:0];
            if (i < 8)
            begin
                exp_q.push_back({8'(i), d});
                exp_regs[i] = d;
            end
            wr_op(7'h2e, 8'(i), d, 2, 1'b1, ak);
            check("fill_ack", (i < 8) ? 16'h7 : 16'h3, {12'h0, ak});
        end
        hold <= 1'b0;
        drain();
        check("drained", 16'h0, 16'(exp_q.size()));
        alert_cond <= 1'b1;
        repeat (4) @(posedge clock);
        check("alert_set", 16'h1, {15'h0, alert_oe});
        rd_op(7'h0c, ack, got);
        check("ara", {7'h0, 1'b1, 7'h2e, 1'b0}, {7'h0, ack, got});
        alert_cond <= 1'b0;
        repeat (4) @(posedge clock);
        check("alert_kept", 16'h1, {15'h0, alert_oe});
        status_read <= 1'b1;
        @(posedge clock);
        status_read <= 1'b0;
        repeat (3) @(posedge clock);
        check("alert_clr", 16'h0, {15'h0, alert_oe});
        // Master stalls mid-read while the slave pulls data low
        exp_q.push_back(16'h4012);
        exp_regs[8'h40] = 8'h12;
        wr_op(7'h2e, 8'h40, 8'h12, 2, 1'b1, ak);
        // Timeout off: the stalled read must still be driven, then finish
        timeout_disable <= 1'b1;
        host_u.start();
        host_u.send_byte({7'h2e, 1'b1}, ack);
        repeat (260) @(posedge clock);
        check("no_timeout", 16'h1, {15'h0, sda_oe});
        host_u.recv_byte(got);
        host_u.stop();
        check("late_read", {8'h0, exp_regs[8'h40]}, {8'h0, got});
        timeout_disable <= 1'b0;
        host_u.start();
        host_u.send_byte({7'h2e, 1'b1}, ack);
        repeat (10) @(posedge clock);
        check("stall_drive", 16'h1, {15'h0, sda_oe});
        repeat (250) @(posedge clock);
        check("timeout", 16'h0, {15'h0, sda_oe});
        host_u.stop();
        // Fresh reset in select mode: the pin picks the odd address
        strap_mode <= 1'b0;
        strap_pin  <= 1'b1;
        rst_n      <= 1'b0;
        repeat (4) @(posedge clock);
        check("reset2", 16'h0, {5'h0, sda_oe, alert_oe, wr_valid, rd_ptr});
        rst_n <= 1'b1;
        repeat (20) @(posedge clock);
        wr_op(7'h2e, 8'h20, 8'h00, 1, 1'b1, ak);
        check("strap_old", 16'h0, {12'h0, ak});
        wr_op(7'h2d, 8'h21, 8'h00, 1, 1'b1, ak);
        check("strap_new", 16'h0321, {4'h0, ak, rd_ptr});
        end_sim();
    end
endmodule : tb_top

`default_nettype wire
